// File: dv/psg_acq_monitor.sv
`timescale 1ns/1ns
module psg_acq_monitor #(
   parameter int DW = 12
) (
   input wire logic          clock_in,
   input wire logic          nrst_in,
   input wire logic          edge_mode_in,
   input wire logic [15:0]   edge_width_in,
   input wire logic          window_in,
   input wire logic          evt_ready_in,
   input wire logic [31:0]   evt_data_out,
   input wire logic          evt_valid_out,
   input wire logic [DW-1:0] dac_offset_out,
   input wire logic          busy_out,
   input wire logic          window_echo_output_out,
   input wire logic          window_accepted_indicator_out,
   input wire logic [31:0]   gate_count_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (!nrst_in);
   logic [15:0] len_q;
   // Open length, read at the closing edge
   always_ff @(posedge clock_in) begin
      if (!nrst_in || !window_echo_output_out) len_q <= 16'h0;
      else len_q <= len_q + 16'h1;
   end
   a_busy_covers_window: assert property (window_echo_output_out |-> busy_out)
      else $error("busy low in window");
   a_accept_one_cycle: assert property (window_accepted_indicator_out |=> !window_accepted_indicator_out)
      else $error("accept pulse too long");
   a_accept_opens_echo: assert property (window_accepted_indicator_out |-> window_echo_output_out)
      else $error("accept without echo");
   a_open_ignores_gate: assert property (window_echo_output_out && $past(window_echo_output_out)
      |-> !window_accepted_indicator_out)
      else $error("accept while open");
   a_dead_keeps_busy: assert property ($fell(window_echo_output_out) |-> busy_out[*8])
      else $error("busy dropped in dead time");
   a_dead_no_rearm: assert property ($fell(window_echo_output_out) |-> !window_accepted_indicator_out[*8])
      else $error("rearmed too soon");
   a_edge_width_exact: assert property ($fell(window_echo_output_out) && edge_mode_in
      |-> len_q == edge_width_in)
      else $error("edge window width wrong");
   a_level_follows_pin: assert property ((!edge_mode_in && !window_in)[*5] |-> !window_echo_output_out)
      else $error("window open after pin low");
   a_stream_holds: assert property (evt_valid_out && !evt_ready_in |=> evt_valid_out && $stable(evt_data_out))
      else $error("stream word dropped");
   a_slide_in_span: assert property (dac_offset_out[DW-1:DW-4] == 4'h0)
      else $error("offset out of span");
   a_gate_count_step: assert property (gate_count_out - $past(gate_count_out) <= 32'h1)
      else $error("gate count jumped");
endmodule
bind psg_acq psg_acq_monitor #(.DW(DW)) u_mon (.clock_in, .nrst_in, .edge_mode_in, .edge_width_in, .window_in,
   .evt_ready_in, .evt_data_out, .evt_valid_out, .dac_offset_out, .busy_out, .window_echo_output_out,
   .window_accepted_indicator_out, .gate_count_out);

// File: dv/psg_src.sv
`timescale 1ns/1ns
module psg_src #(
   parameter int NCH = 16
) (
   input  wire logic              clock_in,
   input  wire logic [NCH*12-1:0] amp_in,
   output logic                   window_out,
   output logic                   discard_out,
   output logic [NCH*12-1:0]      sample_out
);
   logic [3:0] dly_q = 4'h0;
   initial begin
      window_out = 1'b0;
      discard_out = 1'b0;
      sample_out = '0;
   end
   // Pulse tops out inside the gate, baseline zero
   always @(posedge clock_in) begin
      dly_q <= {dly_q[2:0], window_out};
      sample_out <= (dly_q[3] && window_out) ? amp_in : '0;
   end
   // Gate of w cycles, one-cycle discard at step r
   task automatic gate(input int w, input int r);
      for (int i = 0; i < w; i++) begin
         @(negedge clock_in);
         window_out = 1'b1;
         discard_out = (i == r);
      end
      @(negedge clock_in);
      window_out = 1'b0;
      discard_out = 1'b0;
   endtask
endmodule

// File: dv/tb_peak_sensing_gate_acquisition.sv
`timescale 1ns/1ns
module tb_peak_sensing_gate_acquisition;
   import psg_pkg::*;
   localparam int NCH = 16;
   logic              clock_in, window_in, discard_input_in, evt_valid_out, evt_last_out, busy_out;
   logic              nrst_in = 1'b0, acq_run_in = 1'b0, edge_mode_in = 1'b0, supp_enable_in = 1'b0;
   logic              slide_enable_in = 1'b0, calib_wr_in = 1'b0, evt_ready_in = 1'b0;
   logic              window_echo_output_out, window_accepted_indicator_out, data_present_indicator_out;
   logic [15:0]       edge_width_in = 16'h0014, gpio_in = 16'hffff, gpio_reg_in = 16'h0;
   logic [15:0]       gpio_out, gpio_oe_out, gpio_state_out;
   logic [NCH*12-1:0] sample_in, amp = '0;
   logic [NCH-1:0]    ch_enable_in = '1;
   logic [27:0]       supp_thresh_in = '0;
   logic [7:0]        calib_addr_in = 8'h0;
   logic [13:0]       calib_data_in = 14'h0;
   logic [3:0]        gpio_dir_out_in = 4'h0;
   psg_gpio_mode_t    gpio_mode_in [4] = '{GM_REGISTER, GM_REGISTER, GM_REGISTER, GM_REGISTER};
   logic [31:0]       evt_data_out, gate_count_out, g;
   logic [11:0]       dac_offset_out, d;
   logic [47:0]       dead_time_out, real_time_out, r;
   logic [31:0]       rx [$];
   int                fail_count, total_checks, acc_n, e_n, b_n, c, a, v [NCH], thr [2];
   int                last_trig = -1;
   initial begin
      clock_in = 1'b0;
      forever #2 clock_in = ~clock_in;
   end
   psg_acq #(.NCH(NCH), .DEPTH(4), .STEP(4)) dut_u (.clock_in, .nrst_in, .acq_run_in, .edge_mode_in,
      .edge_width_in, .window_in, .discard_input_in, .sample_in, .ch_enable_in, .supp_enable_in,
      .supp_thresh_in, .slide_enable_in, .calib_wr_in, .calib_addr_in, .calib_data_in, .gpio_in,
      .gpio_dir_out_in, .gpio_mode_in, .gpio_reg_in, .evt_ready_in, .evt_data_out, .evt_valid_out,
      .evt_last_out, .dac_offset_out, .busy_out, .window_echo_output_out, .window_accepted_indicator_out,
      .data_present_indicator_out, .gate_count_out, .dead_time_out, .real_time_out, .gpio_out,
      .gpio_oe_out, .gpio_state_out);
   psg_src #(.NCH(NCH)) src_u (.clock_in, .amp_in(amp), .window_out(window_in),
      .discard_out(discard_input_in), .sample_out(sample_in));
   always @(posedge clock_in) begin
      if (window_accepted_indicator_out === 1'b1) acc_n++;
      if (window_echo_output_out === 1'b1) e_n++;
      if (busy_out === 1'b1) b_n++;
   end
   task automatic wrap_up();
      $display("checks %0d errors %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic win(input int w, input int rj);
      src_u.gate(w, rj);
      tick(24);
   endtask
   task automatic calfill(input logic [13:0] cv);
      calib_data_in = cv;
      calib_wr_in = 1'b1;
      for (int i = 0; i < 256; i++) begin
         calib_addr_in = 8'(i);
         tick(1);
      end
      calib_wr_in = 1'b0;
   endtask
   task automatic new_amps();
      foreach (v[i]) v[i] = $urandom % 1024;
      v[0] = 1;
      foreach (v[i]) amp[i*12 +: 12] = 12'(v[i]);
   endtask
   // Sink stalls except here; bounded so a lost last flag cannot hang
   task automatic get_pkt();
      int n;
      rx.delete();
      evt_ready_in = 1'b1;
      for (n = 0; n < 200; n++) begin
         @(posedge clock_in);
         if (evt_valid_out === 1'b1) rx.push_back(evt_data_out);
         if (evt_last_out === 1'b1) break;
      end
      tick(1);
      evt_ready_in = 1'b0;
      if (n == 200) check(0, 1);
      if (n == 200) wrap_up();
   endtask
   task automatic check_pkt(input bit discard_input);
      logic [31:0] q [$];
      int pk;
      int cc;
      get_pkt();
      // Calibration only applies while the scale slides
      cc = slide_enable_in ? c : 0;
      for (int i = 0; i < NCH; i++) begin
         pk = (4 * v[i] > cc) ? 4 * v[i] - cc : 0;
         if (!discard_input && ch_enable_in[i] && !(supp_enable_in && pk < thr[i/8])) q.push_back({8'(i), 10'h0, 14'(pk)});
      end
      check(rx.size(), 3 + q.size());
      check(rx[1][31:16], {discard_input, 15'h0});
      check(rx[2][0], 1'b0);
      if (last_trig >= 0) check(rx[0], 32'(last_trig + 1));
      last_trig = int'(rx[0]);
      for (int i = 0; i < q.size() && i + 3 < rx.size(); i++) check(rx[i+3], q[i]);
   endtask
   initial begin
      void'($urandom(32'h7972));
      tick(8);
      nrst_in = 1'b1;
      tick(2);
      acq_run_in = 1'b1;
      for (int m = 0; m < 4; m++) begin
         gpio_dir_out_in = 4'($urandom);
         foreach (gpio_mode_in[i]) gpio_mode_in[i] = psg_gpio_mode_t'(m);
         tick(4);
         check(gpio_oe_out, {{4{gpio_dir_out_in[3]}}, {4{gpio_dir_out_in[2]}},
            {4{gpio_dir_out_in[1]}}, {4{gpio_dir_out_in[0]}}});
      end
      foreach (gpio_mode_in[i]) gpio_mode_in[i] = GM_REGISTER;
      gpio_dir_out_in = 4'hf;
      gpio_reg_in = 16'($urandom);
      tick(4);
      check(gpio_out, gpio_reg_in);
      c = 64 + $urandom % 192;
      calfill(14'(c));
      new_amps();
      e_n = 0;
      b_n = 0;
      win(30, -1);
      check(e_n, 30);
      check(b_n - e_n, 12);
      check(dead_time_out >= 48'(e_n) && dead_time_out <= 48'(b_n + 1), 1);
      check(data_present_indicator_out, 1'b1);
      check_pkt(0);
      tick(3);
      check(data_present_indicator_out, 1'b0);
      // Second edge inside the edge-mode window is counted, not taken
      edge_mode_in = 1'b1;
      g = gate_count_out;
      a = acc_n;
      e_n = 0;
      src_u.gate(2, -1);
      tick(6);
      win(2, -1);
      check(e_n, 20);
      check(gate_count_out, g + 32'h2);
      check(acc_n, a + 1);
      get_pkt();
      last_trig = -1;
      edge_mode_in = 1'b0;
      win(16, 5);
      check_pkt(1);
      thr[0] = $urandom % 4096;
      thr[1] = $urandom % 4096;
      supp_thresh_in = {14'(thr[1]), 14'(thr[0])};
      supp_enable_in = 1'b1;
      ch_enable_in = 16'($urandom);
      new_amps();
      win(30, -1);
      check_pkt(0);
      supp_enable_in = 1'b0;
      ch_enable_in = '1;
      slide_enable_in = 1'b1;
      c = $urandom % 64;
      calfill(14'(c));
      d = dac_offset_out;
      tick(40);
      check(dac_offset_out != d, 1);
      win(30, -1);
      check_pkt(0);
      // Sink stalled: fifth gate finds the buffers full
      a = acc_n;
      repeat (5) win(20, -1);
      check(acc_n, a + 4);
      check(busy_out, 1'b1);
      repeat (4) get_pkt();
      tick(4);
      check(busy_out, 1'b0);
      check(data_present_indicator_out, 1'b0);
      last_trig = -1;
      gpio_dir_out_in = 4'he;
      gpio_mode_in[0] = GM_BUSYVETO;
      gpio_in = 16'hfffe;
      tick(4);
      check(gpio_state_out, gpio_in);
      a = acc_n;
      g = gate_count_out;
      win(20, -1);
      check(acc_n, a);
      check(gate_count_out, g + 32'h1);
      r = real_time_out;
      tick(100);
      check(real_time_out - r, 48'h64);
      wrap_up();
   end
endmodule

// File: rtl/psg_acq.sv
`timescale 1ns/1ns
`include "psg_defines.svh"
module psg_acq #(
   parameter int NCH   = 32,
   parameter int SW    = 12,
   parameter int PW    = 14,
   parameter int DW    = 12,
   parameter int DEPTH = 1024,
   parameter int STEP  = 62500
) (
   input  wire logic                       clock_in,
   input  wire logic                       nrst_in,
   input  wire logic                       acq_run_in,
   input  wire logic                       edge_mode_in,
   input  wire logic [15:0]                edge_width_in,
   input  wire logic                       window_in,
   input  wire logic                       discard_input_in,
   input  wire logic [NCH*SW-1:0]          sample_in,
   input  wire logic [NCH-1:0]             ch_enable_in,
   input  wire logic                       supp_enable_in,
   input  wire logic [NCH/8*PW-1:0]        supp_thresh_in,
   input  wire logic                       slide_enable_in,
   input  wire logic                       calib_wr_in,
   input  wire logic [DW-5:0]              calib_addr_in,
   input  wire logic [PW-1:0]              calib_data_in,
   input  wire logic [15:0]                gpio_in,
   input  wire logic [3:0]                 gpio_dir_out_in,
   input  wire psg_pkg::psg_gpio_mode_t    gpio_mode_in [4],
   input  wire logic [15:0]                gpio_reg_in,
   input  wire logic                       evt_ready_in,
   output logic [31:0]                     evt_data_out,
   output logic                            evt_valid_out,
   output logic                            evt_last_out,
   output logic [DW-1:0]                   dac_offset_out,
   output logic                            busy_out,
   output logic                            window_echo_output_out,
   output logic                            window_accepted_indicator_out,
   output logic                            data_present_indicator_out,
   output logic [31:0]                     gate_count_out,
   output logic [47:0]                     dead_time_out,
   output logic [47:0]                     real_time_out,
   output logic [15:0]                     gpio_out,
   output logic [15:0]                     gpio_oe_out,
   output logic [15:0]                     gpio_state_out
);
   import psg_pkg::*;
   localparam int EW = 1 + 32 + 48 + NCH * PW;
   localparam int AW = $clog2(DEPTH);
   localparam int SPAN = (1 << DW) / `PSG_SPAN_DIV;
   localparam logic [3:0] DEAD_N = 4'(`PSG_DEAD_CYC);

   // Pin inputs pass two flops before any edge logic
   logic win_s, rej_s, win_d1_q;
   logic [15:0] gpio_s;
   psg_sync #(.W(2)) u_sync_win (
      .clock_in (clock_in),
      .nrst_in  (nrst_in),
      .async_in ({window_in, discard_input_in}),
      .sync_out ({win_s, rej_s})
   );
   psg_sync #(.W(16)) u_sync_gpio (
      .clock_in (clock_in),
      .nrst_in  (nrst_in),
      .async_in (gpio_in),
      .sync_out (gpio_s)
   );

   psg_state_t state_q;
   logic [15:0] wcnt_q;
   logic [3:0]  dcnt_q;
   logic        rej_q, full_q;
   logic [47:0] ts_q, ts_open_q;
   logic [1:0]  tdiv_q;
   logic [31:0] trig_q;
   logic [DW-5:0] slide_q, slide_open_q;
   logic [$clog2(STEP+1)-1:0] step_q;
   logic [AW:0] pend_q;
   logic [AW-1:0] wr_q, rd_q;
   logic        run_d1_q;
   logic [EW-1:0] mem [DEPTH];
   logic [PW-1:0] calib [SPAN];

   wire win_rise = win_s & ~win_d1_q;
   wire veto_w;
   wire accept = win_rise & (state_q == ST_ARMED) & acq_run_in & ~full_q & ~veto_w;
   wire is_open = (state_q == ST_OPEN);
   wire close_w = is_open & (edge_mode_in ? (wcnt_q <= 16'h0001) : ~win_s);
   wire pop_w;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         state_q <= ST_ARMED;
         wcnt_q <= '0;
         dcnt_q <= '0;
         win_d1_q <= 1'b0;
      end else begin
         win_d1_q <= win_s;
         case (state_q)
            ST_ARMED: if (accept) begin
               state_q <= ST_OPEN;
               wcnt_q <= edge_width_in;
            end
            ST_OPEN: begin
               wcnt_q <= wcnt_q - 16'h0001;
               if (close_w) begin
                  state_q <= ST_DEAD;
                  // Closing cycle is the first dead cycle, so the gap stays under 50 ns
                  dcnt_q <= DEAD_N - 4'h2;
               end
            end
            ST_DEAD: begin
               dcnt_q <= dcnt_q - 4'h1;
               if (dcnt_q == 4'h0) state_q <= ST_ARMED;
            end
            default: state_q <= ST_ARMED;
         endcase
      end
   end

   // Discard anywhere in the window marks the event
   always_ff @(posedge clock_in) begin
      if (!nrst_in) rej_q <= 1'b0;
      else if (accept) rej_q <= rej_s;
      else if (is_open && rej_s) rej_q <= 1'b1;
   end

   // Counters, timestamp and sliding-scale stepping
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         gate_count_out <= '0;
         dead_time_out <= '0;
         real_time_out <= '0;
         run_d1_q <= 1'b0;
         ts_q <= '0;
         tdiv_q <= '0;
         trig_q <= '0;
         step_q <= '0;
         slide_q <= '0;
         ts_open_q <= '0;
         slide_open_q <= '0;
      end else begin
         run_d1_q <= acq_run_in;
         if (win_rise) gate_count_out <= gate_count_out + 32'h1;
         if (acq_run_in && !run_d1_q) begin
            real_time_out <= '0;
            dead_time_out <= '0;
            ts_q <= '0;
            tdiv_q <= '0;
         end else if (acq_run_in) begin
            real_time_out <= real_time_out + 48'h1;
            if (state_q != ST_ARMED) dead_time_out <= dead_time_out + 48'h1;
            tdiv_q <= tdiv_q + 2'h1;
            if (tdiv_q == 2'(`PSG_TS_DIV - 1)) ts_q <= ts_q + 48'(`PSG_TS_INC);
         end
         if (accept) begin
            trig_q <= trig_q + 32'h1;
            ts_open_q <= ts_q;
            slide_open_q <= slide_q;
         end
         // Slow step keeps each peak spread over many ADC codes
         if (!slide_enable_in) begin
            slide_q <= '0;
            step_q <= '0;
         end else if (step_q == ($bits(step_q))'(STEP - 1)) begin
            step_q <= '0;
            slide_q <= slide_q + 1'b1;
         end else begin
            step_q <= step_q + 1'b1;
         end
      end
   end

   always_ff @(posedge clock_in) begin
      if (calib_wr_in) calib[calib_addr_in] <= calib_data_in;
   end
   wire [PW-1:0] calib_use = slide_enable_in ? calib[slide_open_q] : '0;

   // Channels share one window
   wire [NCH*PW-1:0] peaks_w;
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         wire [PW-1:0] raw;
         psg_chan #(.SW(SW), .PW(PW)) u_ch (
            .clock_in  (clock_in),
            .nrst_in   (nrst_in),
            .open_in   (is_open),
            .start_in  (accept),
            .sample_in (sample_in[g*SW +: SW]),
            .peak_out  (raw),
            .rise_out  ()
         );
         assign peaks_w[g*PW +: PW] = (raw > calib_use) ? raw - calib_use : '0;
      end
   endgenerate

   // Event memory; write at window close
   wire store_w = close_w;
   always_ff @(posedge clock_in) begin
      if (store_w) mem[wr_q] <= {rej_q | rej_s, trig_q, ts_open_q, peaks_w};
   end
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         wr_q <= '0;
         pend_q <= '0;
         full_q <= 1'b0;
         data_present_indicator_out <= 1'b0;
      end else begin
         if (store_w) wr_q <= wr_q + 1'b1;
         pend_q <= pend_q + (store_w ? 1'b1 : 1'b0) - (pop_w ? 1'b1 : 1'b0);
         full_q <= (pend_q + (store_w ? 1'b1 : 1'b0) - (pop_w ? 1'b1 : 1'b0)) == (AW+1)'(DEPTH);
         data_present_indicator_out <= (pend_q + (store_w ? 1'b1 : 1'b0) - (pop_w ? 1'b1 : 1'b0)) != '0;
      end
   end

   // Packet serializer
   psg_ser_t ser_q;
   logic [EW-1:0] cur_q;
   logic [1:0] hidx_q;
   logic [$clog2(NCH)-1:0] cidx_q;
   wire cur_rej = cur_q[EW-1];
   wire [PW-1:0] cur_pk = cur_q[cidx_q*PW +: PW];
   wire [PW-1:0] cur_thr = supp_thresh_in[(cidx_q / `PSG_GRP_SIZE)*PW +: PW];
   wire keep_ch = ch_enable_in[cidx_q] & ~(supp_enable_in & (cur_pk < cur_thr));
   wire last_ch = (cidx_q == ($bits(cidx_q))'(NCH - 1));
   wire slot_free = ~evt_valid_out | evt_ready_in;
   assign pop_w = slot_free & (((ser_q == SR_HDR) & (hidx_q == 2'(`PSG_HDR_WORDS - 1)) & cur_rej)
                               | ((ser_q == SR_CH) & last_ch));

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         ser_q <= SR_IDLE;
         cur_q <= '0;
         hidx_q <= '0;
         cidx_q <= '0;
         rd_q <= '0;
         evt_valid_out <= 1'b0;
         evt_data_out <= '0;
         evt_last_out <= 1'b0;
      end else begin
         if (evt_ready_in) begin
            evt_valid_out <= 1'b0;
            evt_last_out <= 1'b0;
         end
         case (ser_q)
            SR_IDLE: if (pend_q != '0) begin
               cur_q <= mem[rd_q];
               rd_q <= rd_q + 1'b1;
               hidx_q <= '0;
               cidx_q <= '0;
               ser_q <= SR_HDR;
            end
            SR_HDR: if (slot_free) begin
               evt_valid_out <= 1'b1;
               evt_last_out <= 1'b0;
               case (hidx_q)
                  2'h0: evt_data_out <= cur_q[EW-2 -: 32];
                  2'h1: evt_data_out <= {cur_rej, 15'h0, cur_q[EW-34 -: 16]};
                  default: evt_data_out <= cur_q[EW-50 -: 32];
               endcase
               hidx_q <= hidx_q + 2'h1;
               if (hidx_q == 2'(`PSG_HDR_WORDS - 1)) begin
                  evt_last_out <= cur_rej;
                  ser_q <= cur_rej ? SR_IDLE : SR_CH;
               end
            end
            SR_CH: if (slot_free) begin
               // Dropped channels still cost one cycle each
               evt_valid_out <= keep_ch;
               evt_data_out <= {8'(cidx_q), 24'(cur_pk)};
               evt_last_out <= last_ch;
               cidx_q <= cidx_q + 1'b1;
               if (last_ch) ser_q <= SR_IDLE;
            end
            default: ser_q <= SR_IDLE;
         endcase
      end
   end

   // I/O groups; an input group in busy/veto mode can hold off windows
   logic [3:0] veto_grp;
   generate
      for (g = 0; g < `PSG_GPIO_GRPS; g++) begin : g_io
         assign veto_grp[g] = ~gpio_dir_out_in[g] & (gpio_mode_in[g] == GM_BUSYVETO) & ~&gpio_s[g*4 +: 4];
      end
   endgenerate
   assign veto_w = |veto_grp;

   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         busy_out <= 1'b0;
         window_echo_output_out <= 1'b0;
         window_accepted_indicator_out <= 1'b0;
         dac_offset_out <= '0;
         gpio_out <= '0;
         gpio_oe_out <= '0;
         gpio_state_out <= '0;
      end else begin
         busy_out <= (state_q != ST_ARMED) | accept | full_q;
         window_echo_output_out <= accept | (is_open & ~close_w);
         window_accepted_indicator_out <= accept;
         dac_offset_out <= DW'(slide_q);
         gpio_state_out <= gpio_s;
         for (int i = 0; i < `PSG_GPIO_GRPS; i++) begin
            gpio_oe_out[i*4 +: 4] <= {4{gpio_dir_out_in[i]}};
            case (gpio_mode_in[i])
               GM_REGISTER: gpio_out[i*4 +: 4] <= gpio_reg_in[i*4 +: 4];
               GM_TRIGGER:  gpio_out[i*4 +: 4] <= {4{accept | (is_open & ~close_w)}};
               GM_BUSYVETO: gpio_out[i*4 +: 4] <= {4{~((state_q != ST_ARMED) | full_q)}};
               default:     gpio_out[i*4 +: 4] <= {4{accept}};
            endcase
         end
      end
   end
endmodule

// File: rtl/psg_chan.sv
`timescale 1ns/1ns
module psg_chan #(
   parameter int SW = 12,
   parameter int PW = 14
) (
   input  wire logic          clock_in,
   input  wire logic          nrst_in,
   input  wire logic          open_in,
   input  wire logic          start_in,
   input  wire logic [SW-1:0] sample_in,
   output logic      [PW-1:0] peak_out,
   output logic               rise_out
);
   import psg_pkg::*;
   logic [SW-1:0] s1_q, s2_q, s3_q;
   logic [PW-1:0] avg_q;
   wire  [PW-1:0] sum_w = PW'(sample_in) + PW'(s1_q) + PW'(s2_q) + PW'(s3_q);
   // Four-sample moving sum; also gives the 14-bit peak width
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         avg_q <= '0;
      end else begin
         s1_q <= sample_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         avg_q <= sum_w;
      end
   end
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         peak_out <= '0;
         rise_out <= 1'b0;
      end else if (start_in) begin
         peak_out <= '0;
         rise_out <= 1'b0;
      end else if (open_in) begin
         if (sum_w > avg_q) rise_out <= 1'b1;
         if (sum_w > peak_out) peak_out <= sum_w;
      end
   end
endmodule

// File: rtl/psg_defines.svh
`ifndef PSG_DEFINES_SVH
`define PSG_DEFINES_SVH
`define PSG_CLK_NS      4
`define PSG_DEAD_NS     48
`define PSG_DEAD_CYC    ((`PSG_DEAD_NS + `PSG_CLK_NS - 1) / `PSG_CLK_NS)
`define PSG_TS_STEP_NS  8
`define PSG_TS_RES_NS   16
`define PSG_TS_DIV      (`PSG_TS_RES_NS / `PSG_CLK_NS)
`define PSG_TS_INC      (`PSG_TS_RES_NS / `PSG_TS_STEP_NS)
`define PSG_GRP_SIZE    8
`define PSG_GPIO_GRPS   4
`define PSG_GPIO_LINES  16
`define PSG_SPAN_DIV    16
`define PSG_HDR_WORDS   3
`define PSG_REJ_BIT     31
`define PSG_CH_POS      24
`endif

// File: rtl/psg_pkg.sv
package psg_pkg;
   typedef enum logic [2:0] {
      ST_ARMED = 3'b001,
      ST_OPEN  = 3'b010,
      ST_DEAD  = 3'b100
   } psg_state_t;
   typedef enum logic [2:0] {
      SR_IDLE = 3'b001,
      SR_HDR  = 3'b010,
      SR_CH   = 3'b100
   } psg_ser_t;
   typedef enum logic [1:0] {
      GM_REGISTER = 2'h0,
      GM_TRIGGER  = 2'h1,
      GM_BUSYVETO = 2'h2,
      GM_LEGACY   = 2'h3
   } psg_gpio_mode_t;
endpackage

// File: rtl/psg_sync.sv
`timescale 1ns/1ns
module psg_sync #(
   parameter int W = 1
) (
   input  wire logic         clock_in,
   input  wire logic         nrst_in,
   input  wire logic [W-1:0] async_in,
   output logic      [W-1:0] sync_out
);
   import psg_pkg::*;
   logic [W-1:0] meta_q;
   always_ff @(posedge clock_in) begin
      if (!nrst_in) begin
         meta_q   <= '0;
         sync_out <= '0;
      end else begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end
endmodule
